// ### hw/mcs_byte_port.sv
// mcs_byte_port: pairs serial-bus bytes into 16-bit register words,
// high byte first, and splits read words the same way.
// assumes the serial bus front end delivers decoded byte strobes.
`timescale 1ns/1ps
module mcs_byte_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       ptr_wr,
  input  wire logic [7:0] ptr_in,
  input  wire logic       wr_byte_stb,
  input  wire logic [7:0] wr_byte,
  input  wire logic       rd_byte_stb,
  output logic      [7:0] rd_byte,
  mcs_word_if.port        bus
);

  logic [7:0]  ptr_r;
  logic        wphase_r;
  logic        rphase_r;
  logic [7:0]  whi_r;
  logic [7:0]  rlo_r;
  logic        wr_stb_r;
  logic [15:0] wdata_r;
  logic [7:0]  rd_byte_r;

  // ---------------------------------------------------------------
  // byte pairing
  // ---------------------------------------------------------------
  wire first_rd = rd_byte_stb && !rphase_r;

  // pointer, byte phases and assembled word
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_r     <= 8'h00;
      wphase_r  <= 1'b0;
      rphase_r  <= 1'b0;
      whi_r     <= 8'h00;
      rlo_r     <= 8'h00;
      wr_stb_r  <= 1'b0;
      wdata_r   <= 16'h0000;
      rd_byte_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start || ptr_wr) begin
        wphase_r <= 1'b0;  // new transfer restarts at high byte
        rphase_r <= 1'b0;
      end
      if (ptr_wr) ptr_r <= ptr_in;
      if (wr_byte_stb && !wphase_r) begin
        whi_r    <= wr_byte;
        wphase_r <= 1'b1;
      end else if (wr_byte_stb) begin
        wdata_r  <= {whi_r, wr_byte};  // [R24]
        wr_stb_r <= 1'b1;
        wphase_r <= 1'b0;
      end
      if (first_rd) begin
        rd_byte_r <= bus.rdata[15:8];  // [R24]
        rlo_r     <= bus.rdata[7:0];
        rphase_r  <= 1'b1;
      end else if (rd_byte_stb) begin
        rd_byte_r <= rlo_r;
        rphase_r  <= 1'b0;
      end
    end
  end

  assign bus.ptr    = ptr_r;
  assign bus.wr_stb = wr_stb_r;
  assign bus.wdata  = wdata_r;
  assign bus.rd_stb = first_rd;  // word captured here
  assign rd_byte    = rd_byte_r;

endmodule : mcs_byte_port

// ### hw/mcs_monitor.sv
// mcs_monitor: configuration and status core of a temperature and
// power monitor: measurement configuration, temperature
// configuration, limit flags, converter sequencing and pin control.
// assumes the serial front end delivers decoded byte strobes and the
// converters report results and limit compares at conversion end.
//
// Contract
// [R1] writing one to bit 15 restores all defaults; bit self-clears
// [R2] writing one to bit 14 issues one triggered conversion
// [R3] bus range bit 13: zero 16V, one 32V, default one
// [R4] gain bits 12-11 pick 40, 80, 160 or 320 mV, default 320
// [R5] bus setting bits 10-7, shunt setting bits 6-3, same encoding
// [R6] top bit zero: third bit ignored, low bits give 9 to 12 bits
// [R7] top bit one: 1000 one sample, then 2 to 128 averages
// [R8] mode field: power-down, triggered, off, continuous; default 111
// [R9] mode 000 aborts now; mode 100 finishes current conversion
// [R10] triggered modes stay down until one-shot or temperature trigger
// [R11] continuous bit runs temperature; else one-shot or shut down
// [R12] bits 14-11 enable remote 3,2,1 and local; bit 10 correction
// [R13] rate bits 9-7 double per step from 0.0625 to 8 per second
// [R14] effective rate is limited by the number of enabled channels
// [R15] temperature core triggers voltage core at rate unless code 111
// [R16] bit 2 reads pin; bits 1-0 float, drive low or drive high
// [R17] latch mode holds flags until read; transparent follows limit
// [R18] host reads status once after setup to drop power-up flags
// [R19] status bits 15-11 show shunt, bus and power limit breaches
// [R20] local flag sets above limit plus half hysteresis, clears below
// [R21] remote flags also set on open diode, clear only without it
// [R22] voltage ready sets at end, clears on one-shot or status read
// [R23] separate alert mode bit: zero transparent, one latching
// [R24] registers are 16 bits, moved as two bytes, high first
// [R25] unused status and temperature bits read zero, ignore writes
`timescale 1ns/1ps
module mcs_monitor #(
  parameter int unsigned BASE_PERIOD_CYCLES = mcs_pkg::BASE_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // serial register access, byte level
  input  wire logic       START,
  input  wire logic       PTR_WR,
  input  wire logic [7:0] PTR_IN,
  input  wire logic       WR_BYTE_STB,
  input  wire logic [7:0] WR_BYTE,
  input  wire logic       RD_BYTE_STB,
  output logic      [7:0] RD_BYTE,
  // alert mode selection
  input  wire logic       ALERT_LATCH_MODE,
  // voltage converter
  output logic            VOLT_START,
  output logic            VOLT_ABORT,
  output logic            VOLT_POWERED,
  output logic            VOLT_SHUNT_EN,
  output logic            VOLT_BUS_EN,
  output logic            BUS_RANGE_32V,
  output logic      [1:0] SHUNT_GAIN,
  output logic      [3:0] BUS_RES_BITS,
  output logic      [2:0] BUS_AVG_LOG2,
  output logic      [3:0] SHUNT_RES_BITS,
  output logic      [2:0] SHUNT_AVG_LOG2,
  input  wire logic       VOLT_DONE,
  input  wire logic       SHUNT_OVER,
  input  wire logic       SHUNT_UNDER,
  input  wire logic       BUS_OVER,
  input  wire logic       BUS_UNDER,
  input  wire logic       POWER_OVER,
  // temperature converter
  output logic            TEMP_START,
  output logic            TEMP_ACTIVE,
  output logic      [3:0] TEMP_CH_EN,
  output logic            SERIES_CORR,
  input  wire logic       TEMP_DONE,
  input  wire logic       LOCAL_ABOVE_HI,
  input  wire logic       LOCAL_BELOW_LO,
  input  wire logic [1:0] REMOTE_ABOVE_HI,
  input  wire logic [1:0] REMOTE_BELOW_LO,
  input  wire logic [1:0] REMOTE_OPEN,
  // general-purpose pin
  input  wire logic       GPIO_I,
  output logic            GPIO_O,
  output logic            GPIO_OE
);

  // ---------------------------------------------------------------
  // byte port and word bus
  // ---------------------------------------------------------------
  mcs_word_if bus ();

  mcs_byte_port u_port (
    .clk         (CLOCK),
    .rst         (RST),
    .start       (START),
    .ptr_wr      (PTR_WR),
    .ptr_in      (PTR_IN),
    .wr_byte_stb (WR_BYTE_STB),
    .wr_byte     (WR_BYTE),
    .rd_byte_stb (RD_BYTE_STB),
    .rd_byte     (RD_BYTE),
    .bus         (bus)
  );

  logic [15:0]         vcfg_r;
  logic [15:0]         tcfg_r;
  logic [15:0]         flags_r;
  logic [15:0]         flags_nxt;
  mcs_pkg::mcs_eng_type vst_r;
  mcs_pkg::mcs_eng_type vst_nxt;
  mcs_pkg::mcs_eng_type tst_r;
  mcs_pkg::mcs_eng_type tst_nxt;

  // ---------------------------------------------------------------
  // write and read decode
  // ---------------------------------------------------------------
  wire wr_vcfg  = bus.wr_stb && (bus.ptr == mcs_pkg::PTR_CFG_VOLT);
  wire wr_tcfg  = bus.wr_stb && (bus.ptr == mcs_pkg::PTR_CFG_TEMP);
  wire rd_flags = bus.rd_stb && (bus.ptr == mcs_pkg::PTR_FLAGS);
  wire soft_rst = wr_vcfg && bus.wdata[mcs_pkg::VC_RESET_BIT];  // [R1]
  wire one_shot = wr_vcfg && !soft_rst
                  && bus.wdata[mcs_pkg::VC_ONESHOT_BIT];        // [R2]
  wire core_rst = RST || soft_rst;                              // [R1]

  // configuration registers; reset and one-shot bits never stored
  always_ff @(posedge CLOCK) begin
    if (core_rst) begin
      vcfg_r <= mcs_pkg::VC_RESET_VAL & mcs_pkg::VC_STORED_MASK;
      tcfg_r <= mcs_pkg::TC_RESET_VAL;
    end else begin
      if (wr_vcfg) vcfg_r <= bus.wdata & mcs_pkg::VC_STORED_MASK;
      if (wr_tcfg) tcfg_r <= bus.wdata & mcs_pkg::TC_STORED_MASK; // [R25]
    end
  end

  // ---------------------------------------------------------------
  // measurement configuration decode
  // ---------------------------------------------------------------
  wire [2:0] vmode  = vcfg_r[mcs_pkg::VC_MODE_LSB +: 3];
  wire       v_auto = vmode[2] && (vmode[1:0] != 2'b00);      // [R8]
  wire       v_trig = !vmode[2] && (vmode[1:0] != 2'b00);     // [R8]
  wire       v_pdn  = (vmode == 3'b000);                      // [R9]
  wire [6:0] bus_dec   = mcs_pkg::conv_decode(
                           vcfg_r[mcs_pkg::VC_BUS_LSB +: 4]);   // [R5]
  wire [6:0] shunt_dec = mcs_pkg::conv_decode(
                           vcfg_r[mcs_pkg::VC_SHUNT_LSB +: 4]); // [R5]

  // converter settings to the voltage core
  assign BUS_RANGE_32V  = vcfg_r[mcs_pkg::VC_RANGE_BIT];        // [R3]
  assign SHUNT_GAIN     = vcfg_r[mcs_pkg::VC_GAIN_LSB +: 2];    // [R4]
  assign BUS_RES_BITS   = bus_dec[6:3];                         // [R6]
  assign BUS_AVG_LOG2   = bus_dec[2:0];                         // [R7]
  assign SHUNT_RES_BITS = shunt_dec[6:3];                       // [R6]
  assign SHUNT_AVG_LOG2 = shunt_dec[2:0];                       // [R7]
  assign VOLT_SHUNT_EN  = vmode[0];                             // [R8]
  assign VOLT_BUS_EN    = vmode[1];                             // [R8]

  // ---------------------------------------------------------------
  // temperature configuration decode and rate timer
  // ---------------------------------------------------------------
  wire       t_auto  = tcfg_r[mcs_pkg::TC_AUTO_BIT];
  wire [3:0] t_en    = tcfg_r[mcs_pkg::TC_EN_LSB +: 4];          // [R12]
  wire       any_en  = (t_en != 4'h0);
  wire [2:0] t_rate  = tcfg_r[mcs_pkg::TC_RATE_LSB +: 3];
  wire [2:0] nch     = {2'b00, t_en[0]} + {2'b00, t_en[1]}
                     + {2'b00, t_en[2]} + {2'b00, t_en[3]};
  wire       t_tick;

  mcs_rate_timer #(
    .BASE_CYCLES (BASE_PERIOD_CYCLES)
  ) u_timer (
    .clk  (CLOCK),
    .rst  (core_rst),
    .run  (t_auto && any_en),                                  // [R11]
    .code (t_rate),                                            // [R13]
    .nch  (nch),                                               // [R14]
    .tick (t_tick)
  );

  assign TEMP_CH_EN  = t_en;                                   // [R12]
  assign SERIES_CORR = tcfg_r[mcs_pkg::TC_CORR_BIT];           // [R12]

  // voltage trigger from the temperature core
  wire temp_vtrig = t_tick && (t_rate != mcs_pkg::RATE_FASTEST)
                    && any_en;                                 // [R15]
  wire volt_trig  = v_trig && (one_shot || temp_vtrig);        // [R10]

  // ---------------------------------------------------------------
  // voltage converter sequencing
  // ---------------------------------------------------------------
  always_comb begin
    vst_nxt = vst_r;
    unique case (vst_r)
      mcs_pkg::ENG_IDLE: begin
        if (v_auto || volt_trig) vst_nxt = mcs_pkg::ENG_BUSY;  // [R10]
      end
      mcs_pkg::ENG_BUSY: begin
        if (v_pdn || VOLT_DONE) vst_nxt = mcs_pkg::ENG_IDLE;   // [R9]
      end
    endcase
  end

  // voltage engine state
  always_ff @(posedge CLOCK) begin
    if (core_rst) vst_r <= mcs_pkg::ENG_IDLE;
    else          vst_r <= vst_nxt;
  end

  // start, abort and power to the voltage converter
  assign VOLT_START   = (vst_r == mcs_pkg::ENG_IDLE)
                        && (v_auto || volt_trig) && !core_rst; // [R1]
  assign VOLT_ABORT   = (vst_r == mcs_pkg::ENG_BUSY) && v_pdn; // [R9]
  assign VOLT_POWERED = (vst_r == mcs_pkg::ENG_BUSY);          // [R10]

  // ---------------------------------------------------------------
  // temperature converter sequencing
  // ---------------------------------------------------------------
  wire t_go = any_en && (t_auto ? t_tick : one_shot);          // [R11]

  always_comb begin
    tst_nxt = tst_r;
    unique case (tst_r)
      mcs_pkg::ENG_IDLE: begin
        if (t_go) tst_nxt = mcs_pkg::ENG_BUSY;
      end
      mcs_pkg::ENG_BUSY: begin
        if (TEMP_DONE || !any_en) tst_nxt = mcs_pkg::ENG_IDLE; // [R11]
      end
    endcase
  end

  // temperature engine state
  always_ff @(posedge CLOCK) begin
    if (core_rst) tst_r <= mcs_pkg::ENG_IDLE;
    else          tst_r <= tst_nxt;
  end

  assign TEMP_START  = (tst_r == mcs_pkg::ENG_IDLE) && t_go && !core_rst;
  assign TEMP_ACTIVE = (tst_r == mcs_pkg::ENG_BUSY);

  // ---------------------------------------------------------------
  // limit flags
  // ---------------------------------------------------------------
  wire       latch = ALERT_LATCH_MODE;                         // [R23]
  wire [4:0] v_viol = {SHUNT_OVER, SHUNT_UNDER, BUS_OVER,
                       BUS_UNDER, POWER_OVER};                 // [R19]
  wire [4:0] v_set  = {5{VOLT_DONE}} & v_viol;
  wire [4:0] v_old  = flags_r[mcs_pkg::FL_VOLT_LSB +: 5];
  wire [4:0] v_next = latch ? (v_set | (v_old & {5{!rd_flags}}))
                            : (VOLT_DONE ? v_viol : v_old);    // [R17]

  // temperature flags: local, remote 1, remote 2
  wire [2:0] t_gate = {3{TEMP_DONE}} & {t_en[0], t_en[1], t_en[2]};
  wire [2:0] t_hi   = {LOCAL_ABOVE_HI,
                       REMOTE_ABOVE_HI[0] || REMOTE_OPEN[0],
                       REMOTE_ABOVE_HI[1] || REMOTE_OPEN[1]};  // [R21]
  wire [2:0] t_lo   = {LOCAL_BELOW_LO,                         // [R20]
                       REMOTE_BELOW_LO[0] && !REMOTE_OPEN[0],
                       REMOTE_BELOW_LO[1] && !REMOTE_OPEN[1]}; // [R21]
  wire [2:0] t_set  = t_gate & t_hi;
  wire [2:0] t_clr  = t_gate & t_lo & ~t_hi;
  wire [2:0] t_old  = flags_r[mcs_pkg::FL_TEMP_LSB +: 3];
  wire [2:0] t_next = latch ? (t_set | (t_old & {3{!rd_flags}}))
                            : (t_set | (t_old & ~t_clr));      // [R20]

  // conversion ready flags; a new completion wins over a clear
  wire vdone_next = VOLT_DONE || (flags_r[mcs_pkg::FL_VDONE_BIT]
                    && !rd_flags && !one_shot);                // [R22]
  wire tdone_next = TEMP_DONE || (flags_r[mcs_pkg::FL_TDONE_BIT]
                    && !rd_flags && !one_shot);

  always_comb begin
    flags_nxt = mcs_pkg::FL_RESET_VAL;                         // [R25]
    flags_nxt[mcs_pkg::FL_VOLT_LSB +: 5] = v_next;
    flags_nxt[mcs_pkg::FL_TEMP_LSB +: 3] = t_next;
    flags_nxt[mcs_pkg::FL_VDONE_BIT]     = vdone_next;
    flags_nxt[mcs_pkg::FL_TDONE_BIT]     = tdone_next;
  end

  // status register
  always_ff @(posedge CLOCK) begin
    if (core_rst) flags_r <= mcs_pkg::FL_RESET_VAL;
    else          flags_r <= flags_nxt;
  end

  // ---------------------------------------------------------------
  // general-purpose pin and read mux
  // ---------------------------------------------------------------
  wire [1:0] pmode = tcfg_r[mcs_pkg::TC_PMODE_LSB +: 2];
  assign GPIO_OE = pmode[1];                                   // [R16]
  assign GPIO_O  = pmode[0];                                   // [R16]

  // temperature configuration with live pin level in bit 2
  wire [15:0] tcfg_view = tcfg_r | ({15'd0, GPIO_I}
                          << mcs_pkg::TC_PIN_BIT);             // [R16]

  assign bus.rdata =
    (bus.ptr == mcs_pkg::PTR_CFG_VOLT) ? vcfg_r    :
    (bus.ptr == mcs_pkg::PTR_CFG_TEMP) ? tcfg_view :
    (bus.ptr == mcs_pkg::PTR_FLAGS)    ? flags_r   : 16'h0000;

endmodule : mcs_monitor

// ### hw/mcs_rate_timer.sv
// mcs_rate_timer: periodic tick for the temperature core, doubling
// in rate per code step and stretched by the enabled channel count.
// assumes base_cycles is the period of code 000.
`timescale 1ns/1ps
module mcs_rate_timer #(
  parameter int unsigned BASE_CYCLES = mcs_pkg::BASE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] code,
  input  wire logic [2:0] nch,
  output logic            tick
);

  if (BASE_CYCLES < 32'd1024) begin : g_chk
    $error("base period too short for rate divider");
  end

  localparam logic [31:0] SLOT = 32'(BASE_CYCLES >> mcs_pkg::SLOT_SHIFT);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // ---------------------------------------------------------------
  // period: nominal, or channel slots if longer
  // ---------------------------------------------------------------
  wire [31:0] nominal   = 32'(BASE_CYCLES) >> code;            // [R13]
  wire [31:0] ch_period = 32'({29'd0, nch} * SLOT);
  wire [31:0] period    = (ch_period > nominal) ? ch_period
                                                : nominal;     // [R14]
  wire        wrap      = (cnt_r >= period - 32'd1);

  assign cnt_nxt = !run ? 32'd0 : (wrap ? 32'd0 : cnt_r + 32'd1);
  assign tick    = run && (cnt_r == 32'd0);

  // period counter
  always_ff @(posedge clk) begin
    if (rst) cnt_r <= 32'd0;
    else     cnt_r <= cnt_nxt;
  end

endmodule : mcs_rate_timer

// ### shared/mcs_pkg.sv
// mcs_pkg: register map, field positions, reset values and timing
// constants of the monitor configuration and status block.
// assumes a single 25 MHz core clock.
package mcs_pkg;

  // ---------------------------------------------------------------
  // register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_CFG_VOLT = 8'h00;
  localparam logic [7:0] PTR_CFG_TEMP = 8'h01;
  localparam logic [7:0] PTR_FLAGS    = 8'h02;

  // ---------------------------------------------------------------
  // shunt/bus measurement configuration fields
  // ---------------------------------------------------------------
  localparam int VC_RESET_BIT   = 15;
  localparam int VC_ONESHOT_BIT = 14;
  localparam int VC_RANGE_BIT   = 13;
  localparam int VC_GAIN_LSB    = 11;
  localparam int VC_BUS_LSB     = 7;
  localparam int VC_SHUNT_LSB   = 3;
  localparam int VC_MODE_LSB    = 0;
  localparam logic [15:0] VC_RESET_VAL   = 16'h399F;
  localparam logic [15:0] VC_STORED_MASK = 16'h3FFF;

  // ---------------------------------------------------------------
  // temperature configuration fields
  // ---------------------------------------------------------------
  localparam int TC_AUTO_BIT  = 15;
  localparam int TC_EN_LSB    = 11;
  localparam int TC_CORR_BIT  = 10;
  localparam int TC_RATE_LSB  = 7;
  localparam int TC_PIN_BIT   = 2;
  localparam int TC_PMODE_LSB = 0;
  localparam logic [15:0] TC_RESET_VAL   = 16'hFF80;
  localparam logic [15:0] TC_STORED_MASK = 16'hFF83;
  localparam logic [2:0]  RATE_FASTEST   = 3'b111;

  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int FL_VOLT_LSB  = 11;  // shunt+, shunt-, bus+, bus-, power
  localparam int FL_TEMP_LSB  = 8;   // local, remote 1, remote 2
  localparam int FL_VDONE_BIT = 6;
  localparam int FL_TDONE_BIT = 5;
  localparam logic [15:0] FL_RESET_VAL = 16'h0000;

  // ---------------------------------------------------------------
  // timing: slowest temperature period and per-channel slot
  // ---------------------------------------------------------------
  localparam longint CLK_HZ         = 25_000_000;
  localparam longint SLOW_PERIOD_S  = 16;   // 0.0625 conversions/s
  localparam int     SLOT_SHIFT     = 7;    // 16 s / 128 = 0.125 s
  localparam int unsigned BASE_CYCLES = 32'(SLOW_PERIOD_S * CLK_HZ);

  // converter engine states
  typedef enum logic {ENG_IDLE, ENG_BUSY} mcs_eng_type;

  // converter field decode: {sample bits(4), log2 averages(3)}
  function automatic logic [6:0] conv_decode(input logic [3:0] f);
    logic [6:0] r;
    r = 7'h00;
    if (!f[3]) begin
      r = {4'h9 + {2'b00, f[1:0]}, 3'h0};  // bit 2 ignored
    end else begin
      r = {4'hC, f[2:0]};                  // 12-bit, 1..128 averages
    end
    return r;
  endfunction : conv_decode

endpackage : mcs_pkg

// ### shared/mcs_word_if.sv
// mcs_word_if: word-level register access between the byte port
// and the register core. assumes one clock shared by both ends.
`timescale 1ns/1ps
interface mcs_word_if;
  logic [7:0]  ptr;     // current register pointer
  logic        wr_stb;  // one-cycle pulse: full word written
  logic [15:0] wdata;   // word being written
  logic        rd_stb;  // one-cycle pulse: word captured for reading
  logic [15:0] rdata;   // word at the pointer

  modport port (output ptr, output wr_stb, output wdata,
                output rd_stb, input rdata);
  modport core (input ptr, input wr_stb, input wdata,
                input rd_stb, output rdata);
endinterface : mcs_word_if

// ### tb/mcs_conv_model.sv
// mcs_conv_model: converter stand-in, done pulse a fixed delay
// after each start that is not aborted. assumes the monitor's clock and reset.
`timescale 1ns/1ps
module mcs_conv_model #(
  parameter int DLY = 40
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic vstart,
  input  wire logic vabort,
  input  wire logic tstart,
  output logic      vdone,
  output logic      tdone
);
  int vcnt_r;
  int tcnt_r;
  // count each engine down; done only after the whole run
  always_ff @(posedge clk) begin
    vdone <= !rst && !vabort && vcnt_r == 1;
    tdone <= !rst && tcnt_r == 1;
    if (rst || vabort) vcnt_r <= 0;
    else if (vstart) vcnt_r <= DLY;
    else if (vcnt_r > 0) vcnt_r <= vcnt_r - 1;
    if (rst) tcnt_r <= 0;
    else if (tstart) tcnt_r <= DLY;
    else if (tcnt_r > 0) tcnt_r <= tcnt_r - 1;
  end
endmodule : mcs_conv_model

// ### tb/mcs_monitor_chk.sv
// mcs_monitor_chk: port-level reset-default, sequencing and field checks on mcs_monitor.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mcs_monitor_chk #(
  parameter int unsigned BASE_PERIOD_CYCLES = 1024
) (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       VOLT_START,
  input wire logic       VOLT_ABORT,
  input wire logic       VOLT_POWERED,
  input wire logic       BUS_RANGE_32V,
  input wire logic [1:0] SHUNT_GAIN,
  input wire logic [3:0] BUS_RES_BITS,
  input wire logic [2:0] BUS_AVG_LOG2,
  input wire logic [3:0] SHUNT_RES_BITS,
  input wire logic [2:0] SHUNT_AVG_LOG2,
  input wire logic       TEMP_START,
  input wire logic       TEMP_ACTIVE,
  input wire logic [3:0] TEMP_CH_EN,
  input wire logic       SERIES_CORR,
  input wire logic       GPIO_OE
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_reset_volt: assert property ($fell(RST) |->
    BUS_RANGE_32V && SHUNT_GAIN == 2'b11) else $error("bad volt default");
  chk_reset_temp: assert property ($fell(RST) |->
    TEMP_CH_EN == 4'hF && SERIES_CORR && !GPIO_OE)
    else $error("bad temp default");
  chk_abort_stop: assert property (VOLT_ABORT |->
    VOLT_POWERED ##1 !VOLT_POWERED) else $error("abort did not stop");
  chk_start_idle: assert property (VOLT_START |->
    !VOLT_POWERED ##1 VOLT_POWERED) else $error("start not from idle");
  chk_temp_start: assert property (TEMP_START |=> TEMP_ACTIVE)
    else $error("temp round not active");
  chk_res_single: assert property (BUS_RES_BITS != 4'hC |->
    BUS_AVG_LOG2 == 3'd0) else $error("averaging at low res");
  chk_avg_full: assert property (SHUNT_AVG_LOG2 != 3'd0 |->
    SHUNT_RES_BITS == 4'hC) else $error("averaging not 12 bit");
  chk_res_span: assert property (BUS_RES_BITS >= 4'd9 &&
    BUS_RES_BITS <= 4'd12) else $error("resolution out of span");
endmodule : mcs_monitor_chk

bind mcs_monitor mcs_monitor_chk #(
  .BASE_PERIOD_CYCLES(BASE_PERIOD_CYCLES)) chk_i (.*);

// ### tb/mcs_monitor_tb.sv
// mcs_monitor_tb: byte-port register tests of mcs_monitor.
// assumes mcs_conv_model answers the converter starts.
`timescale 1ns/1ps
module mcs_monitor_tb;
  logic CLOCK = 0, RST = 1, START = 0, PTR_WR = 0, pin = 0;
  logic WR_BYTE_STB = 0, RD_BYTE_STB = 0, ALERT_LATCH_MODE = 1;
  logic [7:0] PTR_IN = 0, WR_BYTE = 0, RD_BYTE;
  logic VOLT_DONE, TEMP_DONE, GPIO_O, GPIO_OE;
  logic SHUNT_OVER, SHUNT_UNDER, BUS_OVER, BUS_UNDER, POWER_OVER;
  logic LOCAL_ABOVE_HI = 0, LOCAL_BELOW_LO = 0;
  logic [1:0] REMOTE_ABOVE_HI = 0, REMOTE_BELOW_LO = 0, REMOTE_OPEN = 0;
  logic VOLT_START, VOLT_ABORT, VOLT_POWERED, VOLT_SHUNT_EN;
  logic VOLT_BUS_EN, BUS_RANGE_32V, TEMP_START, TEMP_ACTIVE;
  logic SERIES_CORR;
  logic [1:0] SHUNT_GAIN;
  logic [3:0] BUS_RES_BITS, SHUNT_RES_BITS, TEMP_CH_EN;
  logic [2:0] BUS_AVG_LOG2, SHUNT_AVG_LOG2;
  logic [4:0] lim = 0;
  logic [15:0] g;
  int fail_count = 0;
  int checks = 0;
  // ---------------------------------------------------------------
  // pin level, clock and parts
  // ---------------------------------------------------------------
  wire GPIO_I = GPIO_OE ? GPIO_O : pin;
  assign {SHUNT_OVER, SHUNT_UNDER, BUS_OVER, BUS_UNDER, POWER_OVER} = lim;
  always #20 CLOCK = ~CLOCK;
  mcs_monitor #(.BASE_PERIOD_CYCLES(1024)) uut (.*);
  mcs_conv_model #(.DLY(40)) conv (.clk(CLOCK), .rst(RST),
    .vstart(VOLT_START), .vabort(VOLT_ABORT), .tstart(TEMP_START),
    .vdone(VOLT_DONE), .tdone(TEMP_DONE));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge CLOCK) {START, PTR_WR, PTR_IN} <= {2'b11, p};
    @(posedge CLOCK) {START, PTR_WR, WR_BYTE_STB} <= 3'b001;
    WR_BYTE <= d[15:8];
    @(posedge CLOCK) WR_BYTE <= d[7:0];
    @(posedge CLOCK) WR_BYTE_STB <= 0;
    repeat (3) @(posedge CLOCK);
  endtask : wr

  // high byte first; mask m of zero discards the word
  task automatic rd(input logic [7:0] p, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF);
    @(posedge CLOCK) {START, PTR_WR, PTR_IN} <= {2'b11, p};
    @(posedge CLOCK) {START, PTR_WR, RD_BYTE_STB} <= 3'b001;
    @(posedge CLOCK) #1 g[15:8] = RD_BYTE;
    @(posedge CLOCK) RD_BYTE_STB <= 0;
    #1 g[7:0] = RD_BYTE;
    if (m != 0) chk(g & m, e);
  endtask : rd

  task automatic wt(input logic v);
    int n;
    n = 0;
    while (VOLT_POWERED !== v && n < 200) begin
      @(posedge CLOCK);
      n++;
    end
    if (n == 200) begin
      fail_count++;
      $display("unexpected at %0t: converter wait ran out", $time);
      end_sim();
    end
  endtask : wt

  // one-shot conversion with given limit compares
  task automatic shot(input logic [4:0] l);
    lim <= l;
    wr(8'h00, 16'h4A7B);
    wt(1);
    wt(0);
  endtask : shot

  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 0;
    rd(8'h00, 16'h399F);
    rd(8'h01, 16'hFF80);
    rd(8'h05, 16'h0000);
    $display("test defaults done");
    for (int m = 0; m < 4; m++) begin
      pin <= m[0];
      wr(8'h01, 16'h03F8 | 16'(m));
      chk({14'h0, GPIO_OE, GPIO_OE & GPIO_O},
          {14'h0, m[1], m[1] & m[0]});
      rd(8'h01, 16'h0380 | 16'(m) | {13'h0, m[0], 2'b0});
    end
    $display("test pin done");
    wr(8'h00, 16'h0A7B);
    chk(16'({BUS_RANGE_32V, SHUNT_GAIN, BUS_RES_BITS, BUS_AVG_LOG2}),
        16'h00C8);
    chk(16'({SHUNT_RES_BITS, SHUNT_AVG_LOG2, VOLT_SHUNT_EN, VOLT_BUS_EN}),
        16'h019F);
    wr(8'h00, 16'h0A7F);
    wt(1);
    wr(8'h00, 16'h0A78);
    chk(16'(VOLT_POWERED), 16'h0000);
    wr(8'h00, 16'h0A7B);
    rd(8'h02, 16'h0000, 16'h0000);
    $display("test fields done");
    shot(5'b10101);
    lim <= 0;
    rd(8'h02, 16'hA840);
    rd(8'h02, 16'h0000);
    ALERT_LATCH_MODE <= 0;
    shot(5'b01010);
    rd(8'h02, 16'h5040);
    shot(5'b00000);
    rd(8'h02, 16'h0040);
    wr(8'h01, 16'h1800);
    {LOCAL_ABOVE_HI, REMOTE_OPEN} <= 3'b101;
    shot(5'b00000);
    rd(8'h02, 16'h0660);
    {LOCAL_ABOVE_HI, LOCAL_BELOW_LO, REMOTE_BELOW_LO} <= 4'b0101;
    shot(5'b00000);
    rd(8'h02, 16'h0260);
    wr(8'h01, 16'h8B00);
    chk(16'(VOLT_POWERED), 16'h0001);
    $display("test flags done");
    wr(8'h00, 16'h8000);
    rd(8'h00, 16'h399F);
    rd(8'h01, 16'hFF84);
    $display("test soft reset done");
    end_sim();
  end
endmodule : mcs_monitor_tb
